//--- include/asb_pkg.sv
// shared constants and types of the async serial block
package asb_pkg;
	// ======================================
	// baud generation
	localparam logic [3:0] PRESCALE_DIV1 = 4'h1;
	localparam logic [3:0] PRESCALE_DIV3 = 4'h3;
	localparam logic [3:0] PRESCALE_DIV4 = 4'h4;
	localparam logic [3:0] PRESCALE_DIV13 = 4'hD;
	localparam int BAUD_CNT_W = 20;
	localparam logic [19:0] BAUD_CNT_RST = 20'h0_0000;
	localparam int SAMPLES_PER_BIT = 16;

	// ======================================
	// receive sample positions, counted from 1 at the start edge
	localparam logic [4:0] SMP_FIRST = 5'h01;
	localparam logic [4:0] SMP_EDGE_A = 5'h03;
	localparam logic [4:0] SMP_EDGE_B = 5'h05;
	localparam logic [4:0] SMP_EDGE_C = 5'h07;
	localparam logic [4:0] SMP_CTR_FIRST = 5'h08;
	localparam logic [4:0] SMP_CTR_LAST = 5'h0A;
	localparam logic [4:0] SMP_LAST = 5'h10;

	// ======================================
	// frame sizes and idle detection
	localparam logic [3:0] DATA_BITS_SHORT = 4'h8;
	localparam logic [3:0] DATA_BITS_LONG = 4'h9;
	localparam logic [7:0] IDLE_TICKS_SHORT = 8'hA0;
	localparam logic [7:0] IDLE_TICKS_LONG = 8'hB0;
	localparam logic [3:0] TX_FRAME_SHORT = 4'hA;
	localparam logic [3:0] TX_FRAME_LONG = 4'hB;

	// ======================================
	// reset values
	localparam logic [2:0] HIST_RST = 3'h7;
	localparam logic [10:0] TX_SHIFT_RST = 11'h7FF;
	localparam logic [8:0] WORD_RST = 9'h000;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} asb_rx_state_t;
endpackage

//--- rtl/asb_baud_gen.sv
// baud generator producing a tick at sixteen times the bit rate
`timescale 1ns/10ps
`default_nettype none
module asb_baud_gen (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic enable,
	input wire logic [1:0] presSel,
	input wire logic [2:0] divSel,
	input wire logic [7:0] extDiv,
	output logic tick16
);
	logic [3:0] preVal;
	logic [7:0] divVal;
	logic [7:0] extVal;
	logic [19:0] period;
	logic [19:0] cnt_q;

	always_comb begin
		case (presSel)
			2'h0: preVal = asb_pkg::PRESCALE_DIV1;
			2'h1: preVal = asb_pkg::PRESCALE_DIV3;
			2'h2: preVal = asb_pkg::PRESCALE_DIV4;
			default: preVal = asb_pkg::PRESCALE_DIV13;
		endcase
		divVal = 8'h01 << divSel;
		extVal = (extDiv == 8'h00) ? 8'h01 : extDiv;
		period = 20'(preVal) * 20'(divVal) * 20'(extVal);
	end

	// ======================================
	// divide counter
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= asb_pkg::BAUD_CNT_RST;
			tick16 <= 1'b0;
		end else if (run) begin
			if (!enable) begin
				cnt_q <= asb_pkg::BAUD_CNT_RST;
				tick16 <= 1'b0;
			end else if (cnt_q == period - 20'h0_0001) begin
				cnt_q <= asb_pkg::BAUD_CNT_RST;
				tick16 <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 20'h0_0001;
				tick16 <= 1'b0;
			end
		end else begin
			tick16 <= 1'b0;
		end
	end
endmodule // asb_baud_gen
`default_nettype wire

//--- rtl/asb_fifo2.sv
// small flip-flop buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module asb_fifo2 #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem_q[rdPtr_q];
	assign push = run && inValid && inReady;
	assign pop = run && outValid && outReady;

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					mem_q[i] <= '0;
				end else if (push && wrPtr_q == AW'(i)) begin
					mem_q[i] <= inData;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
			end
			if (push && !pop) begin
				count_q <= count_q + (AW+1)'(1);
			end else if (pop && !push) begin
				count_q <= count_q - (AW+1)'(1);
			end
		end
	end
endmodule // asb_fifo2
`default_nettype wire

//--- rtl/asb_serial.sv
// async serial core: baud, oversampled receiver, mute and wake-up, parity
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - tx rate is clock over 16, prescaler and tx divider; rx has own divider
// - tx and rx dividers each divide by a power of two, 1 to 128
// - extended prescalers divide tx or rx clock further by 1 to 255
// - extended division is active only for a non-zero prescaler value
// - while muted no receive flag is set and no receive interrupt raised
// - idle wake-up clears mute on an idle frame, idle flag stays clear
// - address wake-up: word with top data bit one clears mute, is received normally
// - frame is start, 8 or 9 data bits or 7/8 plus parity, stop
// - address wake-up tests the top data bit, never the parity bit
// - parity bit makes ones count even for select 0, odd for 1
// - with parity on, the top bit of the written word is replaced by parity
// - a failed parity check sets parity error and may request an interrupt
// - sixteen samples per bit; majority of samples 8, 9, 10 is the value
// - noise flagged when the three centre samples of a data bit disagree
// - sampling phase restarts on every start bit
// - start edge valid after three ones; noise if invalid or sample 3/5/7 high
// - noise flagged if any start bit centre sample reads one
// - in wait mode the block runs and its interrupts wake the device
// - in halt mode baud ticks clear, all other state freezes and transfers stop
// - a false start is dropped; its noise is reported with the next frame
// - word length bit selects 8 data bits at 0, 9 data bits at 1
module asb_serial (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic haltMode,
	input wire logic waitMode,
	input wire logic [1:0] common_prescale_sel,
	input wire logic [2:0] tx_divider_sel,
	input wire logic [2:0] rx_divider_sel,
	input wire logic [7:0] tx_ext_prescale_reg,
	input wire logic [7:0] rx_ext_prescale_reg,
	input wire logic wordLen9,
	input wire logic parity_enable,
	input wire logic parity_odd_sel,
	input wire logic parity_irq_enable,
	input wire logic rxIrqEnable,
	input wire logic idleIrqEnable,
	input wire logic wakeAddrMark,
	input wire logic txEnable,
	input wire logic rxEnable,
	input wire logic muteSet,
	input wire logic flagClear,
	input wire logic [8:0] txData,
	input wire logic txValid,
	output logic txReady,
	output logic txLine,
	output logic txBusy,
	input wire logic rxLine,
	output logic [8:0] rxData,
	output logic receiver_mute,
	output logic rx_ready_flag,
	output logic noise_flag,
	output logic parity_error_flag,
	output logic framingFlag,
	output logic idleFlag,
	output logic irqReq,
	output logic wakeReq
);
	// ======================================
	// freeze and baud ticks
	logic run;
	logic txTick;
	logic rxTick;
	assign run = clkEn && !haltMode;

	asb_baud_gen u_txBaud (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(run),
		.enable(txEnable),
		.presSel(common_prescale_sel),
		.divSel(tx_divider_sel),
		.extDiv(tx_ext_prescale_reg),
		.tick16(txTick)
	);

	asb_baud_gen u_rxBaud (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(run),
		.enable(rxEnable),
		.presSel(common_prescale_sel),
		.divSel(rx_divider_sel),
		.extDiv(rx_ext_prescale_reg),
		.tick16(rxTick)
	);

	// ======================================
	// transmit path
	logic [8:0] bufData;
	logic bufValid;
	logic bufPop;
	logic [8:0] txWord;
	logic [10:0] txShift_q;
	logic [3:0] txBitsLeft_q;
	logic [3:0] txSub_q;
	logic txActive_q;

	asb_fifo2 #(
		.WIDTH(9),
		.DEPTH(2)
	) u_txBuf (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(run),
		.inData(txData),
		.inValid(txValid),
		.inReady(txReady),
		.outData(bufData),
		.outValid(bufValid),
		.outReady(bufPop)
	);

	assign bufPop = txEnable && !txActive_q && bufValid;
	assign txBusy = txActive_q;

	always_comb begin
		txWord = bufData;
		if (parity_enable) begin
			if (wordLen9) begin
				txWord[8] = ^bufData[7:0] ^ parity_odd_sel;
			end else begin
				txWord[7] = ^bufData[6:0] ^ parity_odd_sel;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txShift_q <= asb_pkg::TX_SHIFT_RST;
			txBitsLeft_q <= 4'h0;
			txSub_q <= 4'h0;
			txActive_q <= 1'b0;
		end else if (run) begin
			if (bufPop) begin
				// start bit goes out at once, stop bit sits above the data
				txShift_q <= wordLen9 ? {1'b1, txWord, 1'b0} : {2'b11, txWord[7:0], 1'b0};
				txBitsLeft_q <= wordLen9 ? asb_pkg::TX_FRAME_LONG : asb_pkg::TX_FRAME_SHORT;
				txSub_q <= 4'h0;
				txActive_q <= 1'b1;
			end else if (txActive_q && txTick) begin
				txSub_q <= txSub_q + 4'h1;
				if (txSub_q == 4'(asb_pkg::SAMPLES_PER_BIT - 1)) begin
					txShift_q <= {1'b1, txShift_q[10:1]};
					txBitsLeft_q <= txBitsLeft_q - 4'h1;
					if (txBitsLeft_q == 4'h1) begin
						txActive_q <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txLine <= 1'b1;
		end else if (run) begin
			txLine <= txActive_q ? txShift_q[0] : 1'b1;
		end
	end

	// ======================================
	// receive line synchroniser
	logic rxSync1_q;
	logic rxS;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxSync1_q <= 1'b1;
			rxS <= 1'b1;
		end else if (run) begin
			rxSync1_q <= rxLine;
			rxS <= rxSync1_q;
		end
	end

	// ======================================
	// receive sampler
	asb_pkg::asb_rx_state_t rxState_q;
	logic [4:0] smp_q;
	logic [2:0] hist_q;
	logic [2:0] ctr;
	logic ctrMaj;
	logic ctrOdd;
	logic edgeNoise_q;
	logic frameNoise_q;
	logic pendNoise_q;
	logic [8:0] rxShift_q;
	logic [3:0] bitCnt_q;
	logic [3:0] nBits;
	logic [7:0] idleCnt_q;
	logic idleArmed_q;
	logic idleEvent;
	logic rxDone;
	logic stopBad;
	logic [8:0] word;
	logic addrBit;
	logic parityBad;

	assign ctr = {hist_q[1:0], rxS};
	assign ctrMaj = (ctr[0] & ctr[1]) | (ctr[0] & ctr[2]) | (ctr[1] & ctr[2]);
	assign ctrOdd = (ctr != 3'h0) && (ctr != 3'h7);
	assign nBits = wordLen9 ? asb_pkg::DATA_BITS_LONG : asb_pkg::DATA_BITS_SHORT;
	assign rxDone = rxTick && rxState_q == asb_pkg::RX_STOP && smp_q == asb_pkg::SMP_CTR_LAST;
	assign stopBad = !ctrMaj;
	assign idleEvent = rxTick && rxState_q == asb_pkg::RX_IDLE && rxS && idleArmed_q
		&& idleCnt_q == ((wordLen9 ? asb_pkg::IDLE_TICKS_LONG : asb_pkg::IDLE_TICKS_SHORT) - 8'h01);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxState_q <= asb_pkg::RX_IDLE;
			smp_q <= asb_pkg::SMP_FIRST;
			hist_q <= asb_pkg::HIST_RST;
			edgeNoise_q <= 1'b0;
			frameNoise_q <= 1'b0;
			rxShift_q <= asb_pkg::WORD_RST;
			bitCnt_q <= 4'h0;
		end else if (run) begin
			if (!rxEnable) begin
				rxState_q <= asb_pkg::RX_IDLE;
				hist_q <= asb_pkg::HIST_RST;
			end else if (rxTick) begin
				hist_q <= ctr;
				smp_q <= (smp_q == asb_pkg::SMP_LAST) ? asb_pkg::SMP_FIRST : smp_q + 5'h01;
				case (rxState_q)
					asb_pkg::RX_IDLE: begin
						if (!rxS) begin
							// sample phase restarts here
							rxState_q <= asb_pkg::RX_START;
							smp_q <= asb_pkg::SMP_FIRST + 5'h01;
							edgeNoise_q <= (hist_q != 3'h7);
						end
					end
					asb_pkg::RX_START: begin
						if ((smp_q == asb_pkg::SMP_EDGE_A || smp_q == asb_pkg::SMP_EDGE_B
							|| smp_q == asb_pkg::SMP_EDGE_C) && rxS) begin
							edgeNoise_q <= 1'b1;
						end
						if (smp_q == asb_pkg::SMP_CTR_LAST) begin
							if (ctrMaj) begin
								rxState_q <= asb_pkg::RX_IDLE;
							end else begin
								frameNoise_q <= edgeNoise_q || (ctr != 3'h0);
							end
						end
						if (smp_q == asb_pkg::SMP_LAST) begin
							rxState_q <= asb_pkg::RX_DATA;
							bitCnt_q <= 4'h0;
						end
					end
					asb_pkg::RX_DATA: begin
						if (smp_q == asb_pkg::SMP_CTR_LAST) begin
							rxShift_q <= {ctrMaj, rxShift_q[8:1]};
							if (ctrOdd) begin
								frameNoise_q <= 1'b1;
							end
						end
						if (smp_q == asb_pkg::SMP_LAST) begin
							bitCnt_q <= bitCnt_q + 4'h1;
							if (bitCnt_q == nBits - 4'h1) begin
								rxState_q <= asb_pkg::RX_STOP;
							end
						end
					end
					asb_pkg::RX_STOP: begin
						if (smp_q == asb_pkg::SMP_CTR_LAST) begin
							// leave early so the next start edge is caught on time
							rxState_q <= asb_pkg::RX_IDLE;
						end
					end
					default: rxState_q <= asb_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// ======================================
	// idle line detection
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			idleCnt_q <= 8'h00;
			idleArmed_q <= 1'b1;
		end else if (run) begin
			if (rxTick) begin
				if (rxState_q != asb_pkg::RX_IDLE || !rxS) begin
					idleCnt_q <= 8'h00;
				end else if (idleArmed_q) begin
					idleCnt_q <= idleCnt_q + 8'h01;
				end
			end
			if (rxDone) begin
				idleArmed_q <= 1'b1;
			end else if (idleEvent) begin
				idleArmed_q <= 1'b0;
			end
		end
	end

	// ======================================
	// received word checks
	assign word = wordLen9 ? rxShift_q : {1'b0, rxShift_q[8:1]};
	assign parityBad = parity_enable && ((^word) != parity_odd_sel);
	always_comb begin
		if (parity_enable) begin
			addrBit = wordLen9 ? word[7] : word[6];
		end else begin
			addrBit = wordLen9 ? word[8] : word[7];
		end
	end

	logic accept;
	logic wakeAddr;
	logic wakeIdle;
	assign wakeAddr = rxDone && receiver_mute && wakeAddrMark && addrBit;
	assign wakeIdle = idleEvent && receiver_mute && !wakeAddrMark;
	assign accept = rxDone && (!receiver_mute || wakeAddr);

	// ======================================
	// mute bit: a software set wins over a wake in the same cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			receiver_mute <= 1'b0;
		end else if (run) begin
			if (muteSet) begin
				receiver_mute <= 1'b1;
			end else if (wakeAddr || wakeIdle) begin
				receiver_mute <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxData <= asb_pkg::WORD_RST;
		end else if (run && accept) begin
			rxData <= word;
		end
	end

	// ======================================
	// status flags: a hardware set wins over a clear
	logic setNoise;
	logic setFalse;
	assign setNoise = accept && (frameNoise_q || pendNoise_q || !ctrMaj || ctrOdd);
	assign setFalse = rxTick && rxEnable && rxState_q == asb_pkg::RX_START
		&& smp_q == asb_pkg::SMP_CTR_LAST && ctrMaj;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pendNoise_q <= 1'b0;
		end else if (run) begin
			if (setFalse && !receiver_mute) begin
				pendNoise_q <= 1'b1;
			end else if (accept) begin
				pendNoise_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_ready_flag <= 1'b0;
			noise_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			framingFlag <= 1'b0;
			idleFlag <= 1'b0;
		end else if (run) begin
			rx_ready_flag <= accept || (rx_ready_flag && !flagClear);
			noise_flag <= setNoise || (noise_flag && !flagClear);
			parity_error_flag <= (accept && parityBad) || (parity_error_flag && !flagClear);
			framingFlag <= (accept && stopBad) || (framingFlag && !flagClear);
			idleFlag <= (idleEvent && !receiver_mute) || (idleFlag && !flagClear);
		end
	end

	// ======================================
	// interrupt request and wait wake-up
	logic irqCombo;
	assign irqCombo = (parity_error_flag && parity_irq_enable)
		|| (rx_ready_flag && rxIrqEnable) || (idleFlag && idleIrqEnable);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irqReq <= 1'b0;
			wakeReq <= 1'b0;
		end else if (run) begin
			irqReq <= irqCombo && !receiver_mute;
			wakeReq <= irqCombo && !receiver_mute && waitMode;
		end
	end
endmodule // asb_serial
`default_nettype wire

//--- verif/asb_serial_asserts.sv
// concurrent checks on the serial core ports
`timescale 1ns/10ps
`default_nettype none
module asb_serial_asserts (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic haltMode,
	input wire logic waitMode,
	input wire logic parity_enable,
	input wire logic flagClear,
	input wire logic txLine,
	input wire logic txBusy,
	input wire logic [8:0] rxData,
	input wire logic receiver_mute,
	input wire logic rx_ready_flag,
	input wire logic noise_flag,
	input wire logic parity_error_flag,
	input wire logic idleFlag,
	input wire logic irqReq,
	input wire logic wakeReq
);
	// ======================================
	// properties
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	flag_sticky_a: assert property ($fell(rx_ready_flag) || $fell(noise_flag) |-> $past(flagClear))
		else $error("status flag fell without a clear pulse");
	noise_with_ready_a: assert property ($rose(noise_flag) |-> rx_ready_flag)
		else $error("noise flag rose without a received word");
	parity_with_ready_a: assert property ($rose(parity_error_flag) |-> rx_ready_flag && parity_enable)
		else $error("parity error without parity check or word");
	mute_no_ready_a: assert property ($rose(rx_ready_flag) |-> !receiver_mute)
		else $error("ready flag rose while muted");
	mute_no_error_a: assert property (receiver_mute && $past(receiver_mute) |-> !$rose(parity_error_flag))
		else $error("parity flag rose while muted");
	idle_wake_quiet_a: assert property ($fell(receiver_mute) |-> !$rose(idleFlag))
		else $error("idle flag set by a wake-up");
	mute_irq_off_a: assert property (receiver_mute && clkEn && !haltMode |=> !irqReq)
		else $error("interrupt request while muted");
	wake_follows_a: assert property ($past(clkEn && !haltMode) |-> wakeReq == (irqReq && $past(waitMode)))
		else $error("wake request does not follow interrupt in wait");
	halt_freeze_a: assert property (haltMode |=> $stable(txLine) && $stable(rxData) && $stable(rx_ready_flag))
		else $error("state moved during halt");
	start_bit_a: assert property ($rose(txBusy) && clkEn && !haltMode |=> !txLine)
		else $error("start bit missing after frame start");
	idle_high_a: assert property (!txBusy |-> txLine)
		else $error("transmit line low outside a frame");
endmodule // asb_serial_asserts

bind asb_serial asb_serial_asserts i_asb_serial_asserts (
	.ref_clk, .nrst, .clkEn, .haltMode, .waitMode, .parity_enable, .flagClear, .txLine, .txBusy,
	.rxData, .receiver_mute, .rx_ready_flag, .noise_flag, .parity_error_flag, .idleFlag, .irqReq, .wakeReq
);
`default_nettype wire

//--- verif/asb_remote_node.sv
// remote serial node: drives the receive line and decodes the transmit line
`timescale 1ns/10ps
`default_nettype none
module asb_remote_node (
	input wire logic ref_clk,
	input wire logic txLine,
	output logic rxLine
);
	initial rxLine = 1'b1;

	// ======================================
	// frame out; mode 1 glitches bit 0, mode 2 sends a false start first, mode 3 glitches the start bit
	task automatic drive(input logic v, input int c);
		repeat (c) begin
			@(posedge ref_clk);
			#1;
			rxLine = v;
		end
	endtask

	task automatic send(input logic [8:0] w, input int n, input int bc, input int mode);
		int i;
		if (mode == 2) begin
			drive(1'b0, 4);
			drive(1'b1, 40);
		end
		if (mode == 3) begin
			drive(1'b0, 8);
			drive(1'b1, 1);
			drive(1'b0, bc - 9);
		end else begin
			drive(1'b0, bc);
		end
		for (i = 0; i < n; i++) begin
			if (mode == 1 && i == 0) begin
				drive(w[0], 8);
				drive(!w[0], 1);
				drive(w[0], bc - 9);
			end else begin
				drive(w[i], bc);
			end
		end
		drive(1'b1, bc);
	endtask

	// ======================================
	// frame in: samples each bit in its middle, start in bit 0
	task automatic recv(input int n, input int bc, output logic [10:0] f);
		int i;
		int t;
		f = '0;
		t = 0;
		while (txLine === 1'b1 && t < 5000) begin
			@(posedge ref_clk);
			t++;
		end
		repeat (bc / 2) @(posedge ref_clk);
		for (i = 0; i <= n + 1; i++) begin
			if (i > 0) begin
				repeat (bc) @(posedge ref_clk);
			end
			f[i] = txLine;
		end
	endtask
endmodule // asb_remote_node
`default_nettype wire

//--- verif/asb_serial_tb_top.sv
// self-checking bench for the serial core
`timescale 1ns/10ps
`default_nettype none
module asb_serial_tb_top;
	logic ref_clk, nrst, clkEn, haltMode, waitMode, wordLen9, parity_enable, parity_odd_sel;
	logic parity_irq_enable, rxIrqEnable, idleIrqEnable, wakeAddrMark, txEnable, rxEnable, muteSet;
	logic flagClear, txValid, txReady, txLine, txBusy, rxLine, receiver_mute, rx_ready_flag;
	logic noise_flag, parity_error_flag, framingFlag, idleFlag, irqReq, wakeReq, b;
	logic [1:0] common_prescale_sel;
	logic [2:0] tx_divider_sel, rx_divider_sel;
	logic [7:0] tx_ext_prescale_reg, rx_ext_prescale_reg;
	logic [8:0] txData, rxData, e;
	logic [10:0] f;
	int err_total, tests_run, i, n, c;
	int pm[4] = '{1, 3, 4, 13};
	int bp[7] = '{0, 1, 2, 3, 0, 0, 0};
	int bt[7] = '{0, 1, 2, 0, 7, 0, 1};
	int be[7] = '{0, 0, 0, 0, 0, 255, 3};

	asb_serial i_asb_serial (
		.ref_clk, .nrst, .clkEn, .haltMode, .waitMode, .common_prescale_sel, .tx_divider_sel,
		.rx_divider_sel, .tx_ext_prescale_reg, .rx_ext_prescale_reg, .wordLen9, .parity_enable,
		.parity_odd_sel, .parity_irq_enable, .rxIrqEnable, .idleIrqEnable, .wakeAddrMark, .txEnable,
		.rxEnable, .muteSet, .flagClear, .txData, .txValid, .txReady, .txLine, .txBusy, .rxLine, .rxData,
		.receiver_mute, .rx_ready_flag, .noise_flag, .parity_error_flag, .framingFlag, .idleFlag,
		.irqReq, .wakeReq
	);
	asb_remote_node i_asb_remote_node (.ref_clk, .txLine, .rxLine);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ======================================
	// helpers
	task automatic tk(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return txLine;
			1: return txBusy;
			2: return rx_ready_flag;
			default: return receiver_mute;
		endcase
	endfunction

	task automatic wait_for(input int k, input logic v);
		int t;
		t = 0;
		while (sig(k) !== v && t < 60000) begin
			tk(1);
			t++;
		end
		if (t == 60000) begin
			check(16'h0000, 16'h0001);
			close_out();
		end
	endtask

	function automatic logic [15:0] fr(input logic [8:0] w, input int k);
		return (16'(w) << 1) | (16'h0001 << (k + 1));
	endfunction

	task automatic cfg(input int p, input int t, input int r, input int x);
		txEnable = 1'b0;
		rxEnable = 1'b0;
		tk(1);
		common_prescale_sel = 2'(p);
		tx_divider_sel = 3'(t);
		rx_divider_sel = 3'(r);
		tx_ext_prescale_reg = 8'(x);
		rx_ext_prescale_reg = 8'(x);
		tk(1);
		txEnable = 1'b1;
		rxEnable = 1'b1;
	endtask

	task automatic put(input logic [8:0] d);
		int t;
		t = 0;
		txData = d;
		txValid = 1'b1;
		while (txReady !== 1'b1 && t < 100) begin
			tk(1);
			t++;
		end
		if (t == 100) begin
			check(16'h0000, 16'h0001);
			close_out();
		end
		tk(1);
		txValid = 1'b0;
		tk(1);
	endtask

	task automatic pulse_mute();
		muteSet = 1'b1;
		tk(1);
		muteSet = 1'b0;
	endtask

	task automatic rx_case(input logic [8:0] w, input int bc, input int mode, input logic rdy,
			input logic [8:0] ew, input logic pe, input logic nf);
		flagClear = 1'b1;
		tk(1);
		flagClear = 1'b0;
		i_asb_remote_node.send(w, wordLen9 ? 9 : 8, bc, mode);
		if (rdy) begin
			wait_for(2, 1'b1);
		end else begin
			tk(4);
		end
		tk(2);
		check(16'(rx_ready_flag), 16'(rdy));
		check(16'(rxData), 16'(ew));
		check(16'(parity_error_flag), 16'(pe));
		check(16'(noise_flag), 16'(nf));
		check(16'(framingFlag), 16'h0000);
	endtask

	// ======================================
	// main sequence
	initial begin
		{nrst, haltMode, waitMode, wordLen9, parity_enable, parity_odd_sel, parity_irq_enable} = '0;
		{rxIrqEnable, idleIrqEnable, wakeAddrMark, txEnable, rxEnable, muteSet, flagClear, txValid} = '0;
		{common_prescale_sel, tx_divider_sel, rx_divider_sel, tx_ext_prescale_reg, rx_ext_prescale_reg} = '0;
		txData = 9'h000;
		clkEn = 1'b1;
		tk(10);
		nrst = 1'b1;
		tk(1);
		check(16'({txLine, txReady, txBusy, rx_ready_flag, receiver_mute, irqReq}), 16'h0030);
		$display("test reset done");
		for (i = 0; i < 7; i++) begin
			cfg(bp[i], bt[i], bt[i], be[i]);
			put(9'h002);
			wait_for(0, 1'b0);
			wait_for(0, 1'b1);
			c = 0;
			while (txLine === 1'b1 && c < 5000) begin
				tk(1);
				c++;
			end
			check(16'(c), 16'(16 * pm[bp[i]] * (1 << bt[i]) * (be[i] == 0 ? 1 : be[i])));
			wait_for(1, 1'b0);
		end
		$display("test baud done");
		cfg(0, 0, 0, 0);
		for (i = 0; i < 4; i++) begin
			wordLen9 = i[1];
			parity_enable = i[0];
			parity_odd_sel = i[1];
			n = wordLen9 ? 9 : 8;
			e = 9'h1B5 & ((9'h001 << n) - 9'h001);
			if (parity_enable) begin
				e[n - 1] = 1'b0;
				e[n - 1] = ^e ^ parity_odd_sel;
			end
			put(9'h1B5);
			i_asb_remote_node.recv(n, 16, f);
			check(16'(f), fr(e, n));
			wait_for(1, 1'b0);
		end
		$display("test frames done");
		{wordLen9, parity_enable, parity_odd_sel, txEnable} = '0;
		put(9'h0C3);
		put(9'h03C);
		check(16'(txReady), 16'h0000);
		txEnable = 1'b1;
		i_asb_remote_node.recv(8, 16, f);
		check(16'(f), fr(9'h0C3, 8));
		i_asb_remote_node.recv(8, 16, f);
		check(16'(f), fr(9'h03C, 8));
		wait_for(1, 1'b0);
		put(9'h0F0);
		tk(40);
		haltMode = 1'b1;
		tk(1);
		b = txLine;
		tk(60);
		check(16'({txLine, txBusy}), 16'({b, 1'b1}));
		haltMode = 1'b0;
		clkEn = 1'b0;
		tk(1);
		b = txLine;
		tk(60);
		check(16'({txLine, txBusy}), 16'({b, 1'b1}));
		clkEn = 1'b1;
		wait_for(1, 1'b0);
		$display("test buffer and halt done");
		{rxIrqEnable, parity_irq_enable, waitMode} = 3'b111;
		rx_case(9'h0A5, 16, 0, 1'b1, 9'h0A5, 1'b0, 1'b0);
		rx_case(9'h05A, 16, 1, 1'b1, 9'h05A, 1'b0, 1'b1);
		rx_case(9'h033, 16, 2, 1'b1, 9'h033, 1'b0, 1'b1);
		rx_case(9'h05A, 16, 3, 1'b1, 9'h05A, 1'b0, 1'b1);
		wordLen9 = 1'b1;
		rx_case(9'h1C6, 16, 0, 1'b1, 9'h1C6, 1'b0, 1'b0);
		{wordLen9, rxIrqEnable, parity_enable} = 3'b001;
		rx_case(9'h035, 16, 0, 1'b1, 9'h035, 1'b0, 1'b0);
		check(16'(irqReq), 16'h0000);
		rx_case(9'h0B5, 16, 0, 1'b1, 9'h0B5, 1'b1, 1'b0);
		check(16'({irqReq, wakeReq}), 16'h0003);
		cfg(0, 0, 1, 0);
		rx_case(9'h066, 32, 0, 1'b1, 9'h066, 1'b0, 1'b0);
		cfg(0, 0, 0, 0);
		idleIrqEnable = 1'b1;
		tk(200);
		check(16'({idleFlag, irqReq, wakeReq}), 16'h0007);
		$display("test receive done");
		wakeAddrMark = 1'b1;
		pulse_mute();
		rx_case(9'h080, 16, 0, 1'b0, 9'h066, 1'b0, 1'b0);
		check(16'(receiver_mute), 16'h0001);
		rx_case(9'h0C0, 16, 0, 1'b1, 9'h0C0, 1'b0, 1'b0);
		check(16'(receiver_mute), 16'h0000);
		wakeAddrMark = 1'b0;
		pulse_mute();
		wait_for(3, 1'b0);
		check(16'({receiver_mute, idleFlag}), 16'h0000);
		$display("test mute done");
		close_out();
	end
endmodule // asb_serial_tb_top
`default_nettype wire
